// [shared/pin_cfg_pkg.sv]
// Package: constants for the switch strap decoder and general purpose pin mux.
// Assumes a 10 MHz core clock and one asynchronous active-high reset.
package pin_cfg_pkg;

    // =========================================================
    // Clock and bus rates
    // =========================================================
    localparam int unsigned CORE_CLK_HZ    = 10_000_000;
    localparam int unsigned SLOW_BUS_HZ    = 100_000;
    localparam int unsigned FAST_BUS_HZ    = 400_000;
    // Half period of the bus clock in core cycles, rounded down
    localparam int unsigned SLOW_HALF_CYC  = CORE_CLK_HZ / (2 * SLOW_BUS_HZ);
    localparam int unsigned FAST_HALF_CYC  = CORE_CLK_HZ / (2 * FAST_BUS_HZ);
    localparam int unsigned DIV_W          = 8;

    // =========================================================
    // Pin set and alternate function positions
    // =========================================================
    localparam int unsigned GPIO_W         = 11;
    localparam int unsigned PIN_DOWN2_RST  = 0;
    localparam int unsigned PIN_DOWN4_RST  = 1;
    localparam int unsigned PIN_EXP_IRQ0   = 2;
    localparam int unsigned PIN_EXP_IRQ3   = 5;
    localparam int unsigned PIN_SPARE      = 6;
    localparam int unsigned PIN_EVENT      = 7;
    localparam int unsigned PIN_DOWN1_RST  = 8;
    localparam int unsigned PIN_DOWN3_RST  = 9;
    localparam int unsigned PIN_DOWN5_RST  = 10;
    // Pins whose alternate function is an output
    localparam logic [10:0] ALT_OUT_MASK   = 11'h783;

    // =========================================================
    // Registers
    // =========================================================
    localparam int unsigned ADDR_W         = 4;
    localparam logic [3:0]  OFS_GPIO_ALT   = 4'h0;
    localparam logic [3:0]  OFS_GPIO_DIR   = 4'h1;
    localparam logic [3:0]  OFS_GPIO_OUT   = 4'h2;
    localparam logic [3:0]  OFS_GPIO_IN    = 4'h3;
    localparam logic [3:0]  OFS_FUNC_CTL   = 4'h4;
    localparam logic [3:0]  OFS_STRAPS     = 4'h5;
    localparam logic [3:0]  OFS_IRQ_STAT   = 4'h6;
    localparam logic [3:0]  OFS_IRQ_MASK   = 4'h7;
    localparam logic [10:0] GPIO_ALT_RST   = 11'h000;
    localparam logic [10:0] GPIO_DIR_RST   = 11'h000;
    localparam logic [10:0] GPIO_OUT_RST   = 11'h000;
    localparam logic [6:0]  FUNC_CTL_RST   = 7'h00;
    localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
    localparam logic [6:0]  EEPROM_ADDR_BASE = 7'h50;

    // Management clock generator states
    typedef enum logic [2:0] {
        MCLK_IDLE = 3'h1,
        MCLK_LOW  = 3'h2,
        MCLK_HIGH = 3'h4
    } mclk_state_t;

endpackage : pin_cfg_pkg

// [core/mgmt_clock_gen.sv]
// Master management-bus clock generator: toggles only while a transfer runs.
// Assumes the speed select is stable (captured strap) and the request is a level.
module mgmt_clock_gen
    import pin_cfg_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic slow_sel,
    input  wire logic busy,
    output logic      clk_oe,
    output logic      clk_tick
);

    mclk_state_t      state_reg;
    mclk_state_t      state_next;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic [DIV_W-1:0] half;

    // =========================================================
    // Divider and phase machine
    // =========================================================
    // Slow strap fixes the half period; no software path reaches it
    assign half = slow_sel ? DIV_W'(SLOW_HALF_CYC - 1) : DIV_W'(FAST_HALF_CYC - 1);

    // Next phase: clock held idle high unless a transfer is in progress
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        clk_tick   = 1'b0;
        case (state_reg)
            MCLK_IDLE: begin
                cnt_next = '0;
                if (busy) begin
                    state_next = MCLK_LOW;
                end
            end
            MCLK_LOW: begin
                if (cnt_reg == half) begin
                    cnt_next   = '0;
                    state_next = MCLK_HIGH;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            MCLK_HIGH: begin
                if (cnt_reg == half) begin
                    cnt_next   = '0;
                    clk_tick   = 1'b1;
                    state_next = busy ? MCLK_LOW : MCLK_IDLE;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = MCLK_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    // Register the phase
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= MCLK_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Open-drain: pull low only in the low phase
    assign clk_oe = (state_reg == MCLK_LOW);

endmodule : mgmt_clock_gen

// [core/pin_cfg_mux.sv]
// Strap decoder and general purpose pin mux of the switch.
// Assumes straps are synchronous to core_clk and static after reset release.
//
// Contract
// - Each pin: software GPIO or fixed alternate
// - Alt pins 0,8,9 drive port 2,1,3 resets
// - Alt pins 1,10 drive port 4,5 resets
// - Alt pins 2-5 take expander interrupts 0-3
// - Alt pin 7 drives system event output
// - Alt pin 6 is input only
// - EEPROM address bits 4:1 from straps
// - Target answers when bits 5,3:1 match
// - Management clock toggles only during accesses
// - Slow strap picks 100 KHz else 400 KHz
// - Merge low: one x8 port, else two x4
// - Downstream common clock strap is reported
// - Upstream common clock strap is reported
// - Names ending _n are asserted low
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module pin_cfg_mux
    import pin_cfg_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   irq,
    // Straps
    input  wire logic [3:0]        eeprom_bus_addr_strap,
    input  wire logic [3:0]        target_bus_addr_strap,
    input  wire logic              mgmt_slow_speed_select,
    input  wire logic              port01_merge_n,
    input  wire logic              common_clock_down,
    input  wire logic              common_clock_up,
    // General purpose pins
    input  wire logic [GPIO_W-1:0] gpio_in,
    output logic      [GPIO_W-1:0] gpio_out,
    output logic      [GPIO_W-1:0] gpio_oe,
    // Management bus master clock pin and engine side
    input  wire logic              mgmt_busy,
    output logic                   host_side_mgmt_clock_out,
    output logic                   host_side_mgmt_clock_oe,
    output logic                   mgmt_bit_tick,
    output logic      [6:0]        eeprom_addr,
    // Target bus address match
    input  wire logic [6:0]        target_rx_addr,
    output logic                   target_addr_match,
    // Decoded configuration
    output logic                   port0_x8,
    output logic                   port1_enable,
    output logic                   down_common_clock,
    output logic                   up_common_clock,
    output logic                   mgmt_slow_mode,
    output logic      [3:0]        expander_irq
);

    // =========================================================
    // Strap capture
    // =========================================================
    logic                  cap_done_reg;
    logic                  cap_done_next;
    logic [11:0]           strap_reg;
    logic [11:0]           strap_next;
    logic [11:0]           strap_live;

    assign strap_live = {eeprom_bus_addr_strap, target_bus_addr_strap, mgmt_slow_speed_select,
                         port01_merge_n, common_clock_down, common_clock_up};

    // Take the straps on the first edge after release, then freeze
    always_comb begin
        strap_next    = strap_reg;
        cap_done_next = 1'b1;
        if (!cap_done_reg) begin
            strap_next = strap_live;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_done_reg <= 1'b0;
            strap_reg    <= '0;
        end else begin
            cap_done_reg <= cap_done_next;
            strap_reg    <= strap_next;
        end
    end

    // Decoded strap meanings
    assign eeprom_addr       = {EEPROM_ADDR_BASE[6:5], strap_reg[11:8],
                                EEPROM_ADDR_BASE[0]};
    assign target_addr_match = (target_rx_addr[5] == strap_reg[7])
                             && (target_rx_addr[3:1] == strap_reg[6:4]);
    assign mgmt_slow_mode    = strap_reg[3];
    assign port0_x8          = ~strap_reg[2];
    assign port1_enable      = strap_reg[2];
    assign down_common_clock = strap_reg[1];
    assign up_common_clock   = strap_reg[0];

    // =========================================================
    // Management clock
    // =========================================================
    logic mclk_oe;

    mgmt_clock_gen u_mclk (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .slow_sel (strap_reg[3]),
        .busy     (mgmt_busy & cap_done_reg),
        .clk_oe   (mclk_oe),
        .clk_tick (mgmt_bit_tick)
    );

    assign host_side_mgmt_clock_out = 1'b0;
    assign host_side_mgmt_clock_oe  = mclk_oe;

    // =========================================================
    // Registers
    // =========================================================
    logic [GPIO_W-1:0] alt_reg, alt_next;
    logic [GPIO_W-1:0] dir_reg, dir_next;
    logic [GPIO_W-1:0] dout_reg, dout_next;
    logic [6:0]        func_reg, func_next;
    logic [3:0]        stat_reg, stat_next;
    logic [3:0]        mask_reg, mask_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [3:0]        irq_seen_reg, irq_seen_next;
    logic [3:0]        irq_level;
    logic [3:0]        irq_rise;

    // Expander interrupts, active low on alt pins 2..5
    assign irq_level    = alt_reg[PIN_EXP_IRQ3:PIN_EXP_IRQ0]
                        & ~gpio_in[PIN_EXP_IRQ3:PIN_EXP_IRQ0];
    assign expander_irq = irq_level;
    assign irq_rise     = irq_level & ~irq_seen_reg;

    // Register writes, read mux, sticky status with set over clear
    always_comb begin
        alt_next      = alt_reg;
        dir_next      = dir_reg;
        dout_next     = dout_reg;
        func_next     = func_reg;
        mask_next     = mask_reg;
        stat_next     = stat_reg;
        rdata_next    = '0;
        irq_seen_next = irq_level;
        if (reg_wr) begin
            case (reg_addr)
                OFS_GPIO_ALT: alt_next  = reg_wdata[GPIO_W-1:0];
                OFS_GPIO_DIR: dir_next  = reg_wdata[GPIO_W-1:0];
                OFS_GPIO_OUT: dout_next = reg_wdata[GPIO_W-1:0];
                OFS_FUNC_CTL: func_next = reg_wdata[6:0];
                OFS_IRQ_MASK: mask_next = reg_wdata[3:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_GPIO_ALT: rdata_next = {21'h000000, alt_reg};
                OFS_GPIO_DIR: rdata_next = {21'h000000, dir_reg};
                OFS_GPIO_OUT: rdata_next = {21'h000000, dout_reg};
                OFS_GPIO_IN:  rdata_next = {21'h000000, gpio_in};
                OFS_FUNC_CTL: rdata_next = {25'h0000000, func_reg};
                OFS_STRAPS:   rdata_next = {20'h00000, strap_reg};
                OFS_IRQ_STAT: begin
                    rdata_next = {28'h0000000, stat_reg};
                    stat_next  = 4'h0;
                end
                OFS_IRQ_MASK: rdata_next = {28'h0000000, mask_reg};
                default:      rdata_next = '0;
            endcase
        end
        stat_next = stat_next | irq_rise;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alt_reg      <= GPIO_ALT_RST;
            dir_reg      <= GPIO_DIR_RST;
            dout_reg     <= GPIO_OUT_RST;
            func_reg     <= FUNC_CTL_RST;
            mask_reg     <= IRQ_MASK_RST;
            stat_reg     <= 4'h0;
            rdata_reg    <= '0;
            irq_seen_reg <= 4'h0;
        end else begin
            alt_reg      <= alt_next;
            dir_reg      <= dir_next;
            dout_reg     <= dout_next;
            func_reg     <= func_next;
            mask_reg     <= mask_next;
            stat_reg     <= stat_next;
            rdata_reg    <= rdata_next;
            irq_seen_reg <= irq_seen_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = |(stat_reg & mask_reg);

    // =========================================================
    // Pin mux
    // =========================================================
    // func bits: 0..4 resets for ports 1..5 (1 = hold in reset), 6 = event
    logic [GPIO_W-1:0] alt_val;

    // Alternate values, reset and event outputs active low
    always_comb begin
        alt_val                = '0;
        alt_val[PIN_DOWN1_RST] = ~func_reg[0];
        alt_val[PIN_DOWN2_RST] = ~func_reg[1];
        alt_val[PIN_DOWN3_RST] = ~func_reg[2];
        alt_val[PIN_DOWN4_RST] = ~func_reg[3];
        alt_val[PIN_DOWN5_RST] = ~func_reg[4];
        alt_val[PIN_EVENT]     = ~func_reg[6];
    end

    // Per pin choice between software GPIO and the fixed function
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi = gi + 1) begin : g_pin
            assign gpio_out[gi] = alt_reg[gi] ? alt_val[gi] : dout_reg[gi];
            assign gpio_oe[gi]  = alt_reg[gi] ? ALT_OUT_MASK[gi] : dir_reg[gi];
        end
    endgenerate

endmodule : pin_cfg_mux

// [test/board_model.sv]
// Board model: strap resistors, open-drain expander interrupt lines, pulled-up pins.
// Assumes the bench picks the strap word and which expanders raise interrupts.
module board_model
    import pin_cfg_pkg::*;
(
    input  wire logic [11:0]       strap_word,
    input  wire logic [3:0]        exp_req,
    input  wire logic [GPIO_W-1:0] gpio_out,
    input  wire logic [GPIO_W-1:0] gpio_oe,
    output logic      [11:0]       straps,
    output logic      [GPIO_W-1:0] gpio_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Pin levels
    // =========================================================
    // Resistors hold each configuration input at its chosen level
    assign straps = strap_word;
    // A raised expander pulls its line low; an undriven pin rises to its pull-up
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ~{5'h00, exp_req, 2'h0});
endmodule : board_model

// [test/pin_cfg_sva.sv]
// Checker: port assertions for the strap decoder and pin mux.
// Assumes it is bound to pin_cfg_mux and straps settle before reset release.
module pin_cfg_sva
    import pin_cfg_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0]  eeprom_bus_addr_strap,
    input wire logic [3:0]  target_bus_addr_strap,
    input wire logic        mgmt_slow_speed_select,
    input wire logic        port01_merge_n,
    input wire logic [10:0] gpio_in,
    input wire logic        mgmt_busy,
    input wire logic        host_side_mgmt_clock_out,
    input wire logic        host_side_mgmt_clock_oe,
    input wire logic [6:0]  eeprom_addr,
    input wire logic [6:0]  target_rx_addr,
    input wire logic        target_addr_match,
    input wire logic        port0_x8,
    input wire logic        port1_enable,
    input wire logic        mgmt_slow_mode,
    input wire logic [3:0]  expander_irq
);
    // =========================================================
    // Strap copy, age since release and clock-low run length
    // =========================================================
    logic [9:0] cap;
    logic [1:0] age;
    logic [7:0] run;
    // Copy straps on the first edge after release; count pulled-low cycles
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap <= 10'h000;
            age <= 2'h0;
            run <= 8'h00;
        end else begin
            if (age == 2'h0) cap <= {eeprom_bus_addr_strap, target_bus_addr_strap,
                                     mgmt_slow_speed_select, port01_merge_n};
            if (age != 2'h3) age <= age + 2'h1;
            run <= host_side_mgmt_clock_oe ? run + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence clk_start;
        $rose(host_side_mgmt_clock_oe);
    endsequence
    sequence phase_end;
        $fell(host_side_mgmt_clock_oe) && mgmt_busy;
    endsequence
    eeprom_addr_a: assert property (age == 2'h3 |-> eeprom_addr[4:1] == cap[9:6])
        else $error("eeprom address bits differ from straps");
    target_match_a: assert property (age == 2'h3 && target_addr_match |->
        {target_rx_addr[5], target_rx_addr[3:1]} == cap[5:2])
        else $error("target match on a foreign address");
    merge_decode_a: assert property (age == 2'h3 |->
        port0_x8 == !cap[0] && port1_enable == cap[0])
        else $error("lane merge decode wrong");
    slow_mode_a: assert property (age == 2'h3 |-> mgmt_slow_mode == cap[1])
        else $error("bus speed differs from strap");
    clock_cause_a: assert property (clk_start |-> $past(mgmt_busy))
        else $error("bus clock started while idle");
    half_period_a: assert property (phase_end |->
        run == (cap[1] ? SLOW_HALF_CYC : FAST_HALF_CYC))
        else $error("bus clock half period wrong");
    clock_pin_a: assert property (host_side_mgmt_clock_out == 1'b0)
        else $error("bus clock pin driven high");
    expander_low_a: assert property ((expander_irq & gpio_in[5:2]) == 4'h0)
        else $error("expander interrupt seen on a high line");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule : pin_cfg_sva

bind pin_cfg_mux pin_cfg_sva chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .eeprom_bus_addr_strap(eeprom_bus_addr_strap),
    .target_bus_addr_strap(target_bus_addr_strap), .gpio_in(gpio_in),
    .mgmt_slow_speed_select(mgmt_slow_speed_select), .port01_merge_n(port01_merge_n),
    .mgmt_busy(mgmt_busy), .host_side_mgmt_clock_out(host_side_mgmt_clock_out),
    .host_side_mgmt_clock_oe(host_side_mgmt_clock_oe), .eeprom_addr(eeprom_addr),
    .target_rx_addr(target_rx_addr), .target_addr_match(target_addr_match),
    .port0_x8(port0_x8), .port1_enable(port1_enable), .mgmt_slow_mode(mgmt_slow_mode),
    .expander_irq(expander_irq));

// [test/tb_top.sv]
// Testbench: straps, register port and bus engine request of the pin mux.
// Assumes the board model on the pins and the checker bound to the design.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_cfg_pkg::*;
    // =========================================================
    // Signals, design and board
    // =========================================================
    logic              core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic              busy = 1'b0, irq, clk_oe, match, x8, p1en, ccd, ccu, slow, tick;
    logic [3:0]        reg_addr = 4'h0, exp_req = 4'h0, exp_irq;
    logic [31:0]       reg_wdata = 32'h0, reg_rdata, rd_val;
    logic [11:0]       strap_word = 12'hA5A, straps;
    logic [6:0]        rx_addr = 7'h00, ee_addr;
    logic [GPIO_W-1:0] gpio_in, gpio_out, gpio_oe;
    int                n_fail = 0, num_checks = 0;
    int unsigned       pin_map [7] = '{PIN_DOWN1_RST, PIN_DOWN2_RST, PIN_DOWN3_RST,
                                       PIN_DOWN4_RST, PIN_DOWN5_RST, 0, PIN_EVENT};
    always #50 core_clk = ~core_clk;
    pin_cfg_mux dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .eeprom_bus_addr_strap(straps[11:8]), .target_bus_addr_strap(straps[7:4]),
        .mgmt_slow_speed_select(straps[3]), .port01_merge_n(straps[2]),
        .common_clock_down(straps[1]), .common_clock_up(straps[0]), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .mgmt_busy(busy),
        .host_side_mgmt_clock_out(), .host_side_mgmt_clock_oe(clk_oe), .mgmt_bit_tick(tick),
        .eeprom_addr(ee_addr), .target_rx_addr(rx_addr), .target_addr_match(match),
        .port0_x8(x8), .port1_enable(p1en), .down_common_clock(ccd), .up_common_clock(ccu),
        .mgmt_slow_mode(slow), .expander_irq(exp_irq));
    board_model board (.strap_word(strap_word), .exp_req(exp_req), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .straps(straps), .gpio_in(gpio_in));
    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd_val = reg_rdata;
    endtask : rd
    task automatic do_reset(input logic [11:0] w);
        @(posedge core_clk);
        strap_word <= w;
        sys_rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : do_reset
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // =========================================================
    // Scenarios
    // =========================================================
    // Decoded straps, then strap changes without reset are ignored
    task automatic t_straps(input logic [11:0] w);
        logic [6:0] flips [4] = '{7'h02, 7'h04, 7'h08, 7'h20};
        strap_word <= ~w;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(ee_addr, {EEPROM_ADDR_BASE[6:5], w[11:8], EEPROM_ADDR_BASE[0]});
        chk({x8, p1en}, {~w[2], w[2]});
        chk({ccd, ccu}, w[1:0]);
        chk(slow, w[3]);
        rd(OFS_STRAPS);
        chk(rd_val, {20'h0, w});
        for (int b = 0; b < 4; b++) begin
            @(posedge core_clk);
            rx_addr <= {1'b0, w[7], 1'b0, w[6:4], 1'b0} ^ flips[b];
            @(negedge core_clk);
            chk(match, 1'b0);
        end
        // Compared bits equal, uncompared bits set: must still match
        @(posedge core_clk);
        rx_addr <= {1'b1, w[7], 1'b1, w[6:4], 1'b1};
        @(negedge core_clk);
        chk(match, 1'b1);
    endtask : t_straps
    // Reset values, unmapped place and plain software pins
    task automatic t_gpio;
        for (int a = 0; a < 8; a++) begin
            if (a == 3 || a == 5) continue;
            rd(a[3:0]);
            chk(rd_val, 32'h0);
        end
        wr(4'hE, 32'hFFFF);
        rd(4'hE);
        chk(rd_val, 32'h0);
        wr(OFS_GPIO_DIR, 32'h7FF);
        wr(OFS_GPIO_OUT, 32'h555);
        chk(gpio_oe, 11'h7FF);
        chk(gpio_out, 11'h555);
        wr(OFS_GPIO_DIR, 32'h0);
        chk(gpio_oe, 11'h000);
        repeat (4) @(posedge core_clk);
        rd(OFS_GPIO_IN);
        chk(rd_val, 32'h7FF);
    endtask : t_gpio
    // Each alternate output asserts low alone; input-only pins released
    task automatic t_alt;
        wr(OFS_GPIO_ALT, 32'h7FF);
        for (int k = 0; k < 7; k++) begin
            if (k == 5) continue;
            wr(OFS_FUNC_CTL, 32'h1 << k);
            chk(gpio_oe, ALT_OUT_MASK);
            chk(gpio_out & ALT_OUT_MASK, ALT_OUT_MASK & ~(11'h1 << pin_map[k]));
        end
        wr(OFS_FUNC_CTL, 32'h0);
        chk(gpio_out & ALT_OUT_MASK, ALT_OUT_MASK);
    endtask : t_alt
    // Expander interrupts: order, mask, sticky status cleared by read
    task automatic t_irq;
        @(posedge core_clk);
        exp_req <= 4'h5;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk(exp_irq, 4'h5);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'hA);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'hF);
        chk(irq, 1'b1);
        rd(OFS_IRQ_STAT);
        chk(rd_val, 32'h5);
        chk(irq, 1'b0);
        @(posedge core_clk);
        exp_req <= 4'h0;
    endtask : t_irq
    // Bus clock pulls low in set half periods only while the engine asks
    task automatic t_clock(input int half);
        int n;
        int ticks = 0;
        @(posedge core_clk);
        busy <= 1'b1;
        for (n = 0; !clk_oe && n < 10; n++) @(negedge core_clk);
        for (n = 0; clk_oe && n < 200; n++) @(negedge core_clk);
        chk(n, half);
        // One bit tick at the close of the released phase
        for (n = 0; !clk_oe && n < 200; n++) begin
            if (tick === 1'b1) ticks++;
            @(negedge core_clk);
        end
        chk(n, half);
        chk(ticks, 1);
        @(posedge core_clk);
        busy <= 1'b0;
        // Let the running low and high phases finish before watching idle
        repeat (120) @(posedge core_clk);
        n = 0;
        repeat (200) begin
            @(negedge core_clk);
            if (clk_oe !== 1'b0 || tick !== 1'b0) n++;
        end
        chk(n, 0);
    endtask : t_clock
    // Main sequence and watchdog
    initial begin
        do_reset(12'hA5A);
        t_straps(12'hA5A);
        t_gpio;
        t_alt;
        t_irq;
        t_clock(SLOW_HALF_CYC);
        do_reset(12'h5A5);
        t_straps(12'h5A5);
        t_clock(FAST_HALF_CYC);
        end_of_test;
    end
    initial begin
        #2_000_000;
        n_fail++;
        end_of_test;
    end
endmodule : tb_top
